// ===== src/smwd_defs.svh
// register map, field positions, reset values and timing counts of the bank timing block
`ifndef SMWD_DEFS_SVH
`define SMWD_DEFS_SVH

`define SMWD_NUM_BANKS 8
`define SMWD_DLY_BASE 8'h00
`define SMWD_CFG_BASE 8'h20
`define SMWD_WST_BASE 8'h40
`define SMWD_REGION_MASK 8'he0

`define SMWD_DLY_LSB 0
`define SMWD_DLY_W 4
`define SMWD_DLY_RST 4'h1

`define SMWD_MW_LSB 6
`define SMWD_MW_RST_ALL 16'h1a12

`define SMWD_WST_LSB 0
`define SMWD_WST_W 5
`define SMWD_WST_RST 5'h1f
`define SMWD_DEN_BIT 8
`define SMWD_DEN_RST 1'b0

`define SMWD_GAP_CYCLES 1

`endif

// ===== src/smwd_pkg.sv
// types shared by the bank timing block
package smwd_pkg;

    typedef enum logic [1:0] {
        MW_8 = 2'b00,
        MW_16 = 2'b01,
        MW_32 = 2'b10,
        MW_RSV = 2'b11
    } smwd_width_t;

    typedef enum logic [1:0] {
        RK_NONE = 2'h0,
        RK_DLY = 2'h1,
        RK_CFG = 2'h2,
        RK_WST = 2'h3
    } smwd_regkind_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_RUN = 3'b010,
        SEQ_GAP = 3'b100
    } smwd_seq_t;

    typedef struct packed {
        logic [3:0] delay;
        logic delayEn;
        logic [4:0] waitCount;
    } smwd_timing_t;

    typedef struct packed {
        logic [2:0] bank;
        logic [23:0] addr;
        logic [1:0] size;
        logic [31:0] data;
    } smwd_req_t;

endpackage

// ===== src/smwd_strobe_gen.sv
// one external write access: chip-select window and half-cycle shifted strobes
`timescale 1ns/1ps
`default_nettype none
`include "smwd_defs.svh"

module smwd_strobe_gen
    import smwd_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [2:0] bank,
    input wire smwd_timing_t timing,
    input wire logic [3:0] laneMask,
    output logic [7:0] csN,
    output logic weN,
    output logic [3:0] blsN,
    output logic dataOe,
    output logic done
);
    smwd_timing_t tim;
    logic [4:0] cnt;
    logic [3:0] mask;
    logic [4:0] weFrom;
    logic weWant;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dataOe <= 1'b0;
            csN <= 8'hff;
            cnt <= 5'h00;
            tim <= '0;
            mask <= 4'h0;
        end else if (start && !dataOe) begin
            dataOe <= 1'b1;
            csN <= ~(8'h01 << bank);
            cnt <= 5'h00;
            tim <= timing;
            mask <= laneMask;
        end else if (dataOe) begin
            // access length is wait count plus one cycle
            if (cnt == tim.waitCount) begin
                dataOe <= 1'b0;
                csN <= 8'hff;
            end else begin
                cnt <= cnt + 5'h01;
            end
        end
    end

    assign done = dataOe && (cnt == tim.waitCount);

    // delay counted in whole cycles, only when enabled
    assign weFrom = tim.delayEn ? {1'b0, tim.delay} : 5'h00;
    // strobe window ends one cycle early; a delay at or past the wait count gives none
    assign weWant = dataOe && (cnt >= weFrom) && (cnt < tim.waitCount);

    // falling-edge copy: on half a cycle after the delay ends, off half a cycle before cs
    always_ff @(negedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            weN <= 1'b1;
            blsN <= 4'hf;
        end else begin
            weN <= ~weWant;
            blsN <= ~({4{weWant}} & mask);
        end
    end

endmodule
`default_nettype wire

// ===== src/smwd_top.sv
// AHB-Lite bank timing registers and split write sequencer for static memory
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "smwd_defs.svh"

module smwd_top
    import smwd_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic reqValid,
    input wire smwd_req_t req,
    output logic reqReady,
    output logic reqDone,
    output logic [7:0] memCsN,
    output logic memWeN,
    output logic [3:0] memBlsN,
    output logic [23:0] memAddr,
    output logic [31:0] memData,
    output logic memDataOe
);
    localparam int NB = `SMWD_NUM_BANKS;
    // width reset codes of all banks, two bits per bank
    localparam logic [15:0] MW_RST = `SMWD_MW_RST_ALL;

    // per-bank register copies
    logic [`SMWD_DLY_W-1:0] dlyReg [NB];
    logic denReg [NB];
    logic [`SMWD_WST_W-1:0] wstReg [NB];
    smwd_width_t mwReg [NB];

    // upper address bits pick the register group
    function automatic smwd_regkind_t kindOf(input logic [7:0] a);
        if ((a & `SMWD_REGION_MASK) == `SMWD_DLY_BASE) begin
            return RK_DLY;
        end else if ((a & `SMWD_REGION_MASK) == `SMWD_CFG_BASE) begin
            return RK_CFG;
        end else if ((a & `SMWD_REGION_MASK) == `SMWD_WST_BASE) begin
            return RK_WST;
        end
        return RK_NONE;
    endfunction

    // only implemented fields appear, all else reads zero
    function automatic logic [31:0] viewOf(
        input smwd_regkind_t k,
        input logic [3:0] dly,
        input logic den,
        input logic [4:0] wst,
        input logic [1:0] mw
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (k)
            RK_DLY: v[`SMWD_DLY_LSB +: `SMWD_DLY_W] = dly;
            RK_CFG: v[`SMWD_MW_LSB +: 2] = mw;
            RK_WST: begin
                v[`SMWD_WST_LSB +: `SMWD_WST_W] = wst;
                v[`SMWD_DEN_BIT] = den;
            end
            RK_NONE: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // ---- bus slave: zero wait states, always OKAY
    logic wrPend;
    logic [7:0] wrAddr;
    logic accept;
    smwd_regkind_t wrKind;
    smwd_regkind_t rdKind;
    logic [2:0] rdIdx;
    logic fwd;
    logic [3:0] rdDly;
    logic rdDen;
    logic [4:0] rdWst;
    logic [1:0] rdMw;

    // every register answers at once: no wait states
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign accept = hsel && hready && htrans[1];
    assign wrKind = kindOf(wrAddr);
    assign rdKind = kindOf(haddr[7:0]);
    assign rdIdx = haddr[4:2];

    // write data follows its address by one cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end else if (hready) begin
            wrPend <= accept && hwrite;
            wrAddr <= haddr[7:0];
        end
    end

    // a read right behind a write to the same word sees the new value
    assign fwd = wrPend && (wrAddr[7:2] == haddr[7:2]);

    always_comb begin
        rdDly = dlyReg[rdIdx];
        rdDen = denReg[rdIdx];
        rdWst = wstReg[rdIdx];
        rdMw = mwReg[rdIdx];
        if (fwd) begin
            rdDly = hwdata[`SMWD_DLY_LSB +: `SMWD_DLY_W];
            rdDen = hwdata[`SMWD_DEN_BIT];
            rdWst = hwdata[`SMWD_WST_LSB +: `SMWD_WST_W];
            rdMw = hwdata[`SMWD_MW_LSB +: 2];
        end
    end

    // read data registered in the address phase, stands in the data phase
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (accept && !hwrite) begin
            hrdata <= viewOf(rdKind, rdDly, rdDen, rdWst, rdMw);
        end
    end

    // ---- per-bank register set
    for (genvar b = 0; b < NB; b++) begin : g_bank
        logic hit;
        assign hit = wrPend && (wrAddr[4:2] == 3'(b));

        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                dlyReg[b] <= `SMWD_DLY_RST;
            end else if (hit && wrKind == RK_DLY) begin
                dlyReg[b] <= hwdata[`SMWD_DLY_LSB +: `SMWD_DLY_W];
            end
        end

        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                mwReg[b] <= smwd_width_t'(MW_RST[2*b +: 2]);
            end else if (hit && wrKind == RK_CFG) begin
                mwReg[b] <= smwd_width_t'(hwdata[`SMWD_MW_LSB +: 2]);
            end
        end

        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                wstReg[b] <= `SMWD_WST_RST;
                denReg[b] <= `SMWD_DEN_RST;
            end else if (hit && wrKind == RK_WST) begin
                wstReg[b] <= hwdata[`SMWD_WST_LSB +: `SMWD_WST_W];
                denReg[b] <= hwdata[`SMWD_DEN_BIT];
            end
        end
    end

    // ---- write sequencer, splitting wide transfers
    // log2 of the bus width in bytes; reserved width acts as 8-bit
    function automatic logic [1:0] widthLog(input smwd_width_t w);
        unique case (w)
            MW_16: return 2'd1;
            MW_32: return 2'd2;
            default: return 2'd0;
        endcase
    endfunction

    smwd_seq_t state;
    smwd_req_t cur;
    logic [1:0] beatsLeft;
    logic take;
    logic start;
    logic done;
    smwd_req_t src;
    logic [1:0] srcSize;
    logic [1:0] wLog;
    logic [1:0] effSize;
    logic [1:0] laneOff;
    logic [3:0] laneMask;
    logic [1:0] next_beats;
    smwd_timing_t timing;

    assign reqReady = (state == SEQ_IDLE);
    assign take = reqValid && reqReady;
    assign start = take || (state == SEQ_GAP);
    // a new request, or the remaining pieces of the one in flight
    assign src = take ? req : cur;
    // size code 3 taken as a whole word
    assign srcSize = (src.size == 2'd3) ? 2'd2 : src.size;
    assign wLog = widthLog(mwReg[src.bank]);

    always_comb begin
        effSize = (srcSize > wLog) ? wLog : srcSize;
        laneOff = src.addr[1:0] & ~(2'b11 << wLog);
        // lanes of one beat, then moved to the addressed lane
        unique case (effSize)
            2'h0: laneMask = 4'h1;
            2'h1: laneMask = 4'h3;
            default: laneMask = 4'hf;
        endcase
        laneMask = 4'(laneMask << laneOff);
        next_beats = 2'd0;
        if (srcSize > wLog) begin
            next_beats = 2'((3'h1 << (srcSize - wLog)) - 3'h1);
        end
    end

    // timing of the bank being started, read when each beat starts
    always_comb begin
        timing.delay = dlyReg[src.bank];
        timing.delayEn = denReg[src.bank];
        timing.waitCount = wstReg[src.bank];
    end

    // idle, one beat running, or one idle cycle between beats
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= SEQ_IDLE;
            beatsLeft <= 2'd0;
            cur <= '0;
        end else begin
            unique case (state)
                SEQ_IDLE: begin
                    if (take) begin
                        state <= SEQ_RUN;
                        cur <= req;
                        beatsLeft <= next_beats;
                    end
                end
                SEQ_RUN: begin
                    if (done) begin
                        if (beatsLeft == 2'd0) begin
                            state <= SEQ_IDLE;
                        end else begin
                            // next piece: advance by bus width
                            state <= SEQ_GAP;
                            beatsLeft <= beatsLeft - 2'd1;
                            cur.addr <= cur.addr + (24'h1 << wLog);
                            cur.data <= cur.data >> (6'd8 << wLog);
                        end
                    end
                end
                SEQ_GAP: state <= SEQ_RUN;
            endcase
        end
    end

    // one-cycle pulse as the last chip-select window closes
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reqDone <= 1'b0;
        end else begin
            reqDone <= (state == SEQ_RUN) && done && (beatsLeft == 2'd0);
        end
    end

    // address and lane-placed data held for the whole beat
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            memAddr <= 24'h00_0000;
            memData <= 32'h0000_0000;
        end else if (start) begin
            memAddr <= src.addr;
            memData <= src.data << {laneOff, 3'b000};
        end
    end

    // chip-select window and strobes of one beat
    smwd_strobe_gen u_strobe (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .start(start),
        .bank(src.bank),
        .timing(timing),
        .laneMask(laneMask),
        .csN(memCsN),
        .weN(memWeN),
        .blsN(memBlsN),
        .dataOe(memDataOe),
        .done(done)
    );

endmodule
`default_nettype wire

// ===== testbench/smwd_mem_model.sv
// static memory seen from its pins: counts access windows and strobe cycles
`timescale 1ns/1ps
`default_nettype none
module smwd_mem_model (
    input wire logic core_clk,
    input wire logic [7:0] memCsN,
    input wire logic memWeN,
    input wire logic [3:0] memBlsN,
    input wire logic [23:0] memAddr,
    input wire logic [31:0] memData
);
    logic [31:0] csCyc = 32'h0;
    logic [31:0] weCyc = 32'h0;
    logic [31:0] beats = 32'h0;
    logic [31:0] firstData = 32'h0;
    logic [23:0] firstAddr = 24'h0;
    logic [23:0] lastAddr = 24'h0;
    logic wasSel = 1'b0;
    logic [3:0] lanes = 4'h0;
    logic [31:0] lastData = 32'h0;
    always @(posedge core_clk) begin
        if (memCsN != 8'hff) begin
            csCyc <= csCyc + 32'h1;
            if (!memWeN) begin
                weCyc <= weCyc + 32'h1;
                lanes <= lanes | ~memBlsN;
            end
            if (!wasSel) begin
                beats <= beats + 32'h1;
                lastAddr <= memAddr;
                lastData <= memData;
                if (beats == 32'h0) begin
                    firstAddr <= memAddr;
                    firstData <= memData;
                end
            end
        end
        wasSel <= memCsN != 8'hff;
    end
endmodule
`default_nettype wire

// ===== testbench/smwd_properties.sv
// strobe and handshake timing checks of the bank timing block
`timescale 1ns/1ps
`default_nettype none
module smwd_top_checker (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic reqDone,
    input wire logic [7:0] memCsN,
    input wire logic memWeN,
    input wire logic [3:0] memBlsN,
    input wire logic memDataOe,
    input wire logic hreadyout,
    input wire logic hresp
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_we_in_cs; !memWeN |-> memCsN != 8'hff; endproperty
    a_we_in_cs: assert property (p_we_in_cs)
        else $error("write strobe outside chip-select");
    property p_we_end; $rose(memWeN) && memCsN != 8'hff |=> &memCsN; endproperty
    a_we_end: assert property (p_we_end)
        else $error("chip-select not released half a cycle after strobe");
    property p_cs_end; $rose(&memCsN) |-> $past(memWeN); endproperty
    a_cs_end: assert property (p_cs_end)
        else $error("strobe still low when chip-select released");
    property p_bls_idle; memWeN |-> memBlsN == 4'hf; endproperty
    a_bls_idle: assert property (p_bls_idle)
        else $error("lane select low without write strobe");
    property p_bls_act; !memWeN |-> memBlsN != 4'hf; endproperty
    a_bls_act: assert property (p_bls_act)
        else $error("no lane select with write strobe");
    property p_one_bank; $onehot0(~memCsN); endproperty
    a_one_bank: assert property (p_one_bank)
        else $error("several chip-selects low");
    property p_busy; memCsN != 8'hff |-> !reqReady; endproperty
    a_busy: assert property (p_busy)
        else $error("request ready during access");
    property p_take; reqValid && reqReady |=> memCsN != 8'hff; endproperty
    a_take: assert property (p_take)
        else $error("accepted request without chip-select");
    property p_done; reqDone |-> &memCsN && !$past(&memCsN); endproperty
    a_done: assert property (p_done)
        else $error("done not at chip-select release");
    property p_cs_len; $fell(&memCsN) |-> ##[1:32] &memCsN; endproperty
    a_cs_len: assert property (p_cs_len)
        else $error("chip-select window too long");
    property p_oe_win; memDataOe == (memCsN != 8'hff); endproperty
    a_oe_win: assert property (p_oe_win)
        else $error("data drive not matching chip-select window");
    property p_bus_ok; hreadyout && !hresp; endproperty
    a_bus_ok: assert property (p_bus_ok)
        else $error("register bus wait or error response");
endmodule
bind smwd_top smwd_top_checker chk_u (.core_clk(core_clk), .arst_n(arst_n),
    .reqValid(reqValid), .reqReady(reqReady), .reqDone(reqDone),
    .memCsN(memCsN), .memWeN(memWeN), .memBlsN(memBlsN), .memDataOe(memDataOe),
    .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// ===== testbench/smwd_top_tb.sv
// register and split write tests of the bank timing block
`timescale 1ns/1ps
`default_nettype none
module smwd_top_tb
    import smwd_pkg::*;
;
    logic core_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, reqValid = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [15:0] mwr = 16'h1a12;
    smwd_req_t req = '0;
    wire logic hreadyout, hresp, reqReady, reqDone, memWeN, memDataOe;
    wire logic [31:0] hrdata, memData;
    wire logic [7:0] memCsN;
    wire logic [3:0] memBlsN;
    wire logic [23:0] memAddr;
    int fails = 0, n_tests = 0, cyc = 0;
    always #20 core_clk = ~core_clk;
    smwd_top dut_u (.core_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .reqValid, .req, .reqReady,
        .reqDone, .memCsN, .memWeN, .memBlsN, .memAddr, .memData, .memDataOe);
    smwd_mem_model mem_u (.core_clk, .memCsN, .memWeN, .memBlsN, .memAddr, .memData);
    task automatic tally_and_finish;
        $display("tests %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic run(input logic [2:0] b, input logic [1:0] mw, input logic [4:0] w,
        input logic [3:0] d, input logic den, input logic [1:0] sz, input logic [31:0] nb,
        input logic [31:0] nwe);
        logic [31:0] step, bm;
        step = (mw == 2'b10) ? 32'h4 : (mw == 2'b01) ? 32'h2 : 32'h1;
        bm = (32'h1 << (step * 32'h8)) - 32'h1;
        bus(1'b1, {3'h1, b, 2'h0}, {24'h0, mw, 6'h0}, rd);
        bus(1'b1, {3'h0, b, 2'h0}, {28'h0, d}, rd);
        bus(1'b1, {3'h2, b, 2'h0}, {23'h0, den, 3'h0, w}, rd);
        bus(1'b0, {3'h1, b, 2'h0}, 32'h0, rd);
        chk(rd, {24'h0, mw, 6'h0});
        mem_u.csCyc = 32'h0;
        mem_u.weCyc = 32'h0;
        mem_u.beats = 32'h0;
        mem_u.lanes = 4'h0;
        reqValid <= 1'b1;
        req <= '{bank: b, addr: 24'h000100, size: sz, data: 32'h5a3c96e1};
        do @(posedge core_clk); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
        do @(posedge core_clk); while (reqDone !== 1'b1);
        chk(mem_u.beats, nb);
        chk(mem_u.csCyc, nb * ({27'h0, w} + 32'h1));
        chk(mem_u.weCyc, nb * nwe);
        chk({8'h0, mem_u.firstAddr}, 32'h100);
        chk({8'h0, mem_u.lastAddr}, 32'h100 + (nb - 32'h1) * step);
        if (mw == 2'b10) chk(mem_u.firstData, 32'h5a3c96e1);
        chk(mem_u.firstData & bm, 32'h5a3c96e1 & bm);
        chk(mem_u.lastData & bm, (32'h5a3c96e1 >> ((nb - 32'h1) * step * 32'h8)) & bm);
        chk({28'h0, mem_u.lanes}, (nwe == 32'h0) ? 32'h0 : (32'h1 << step) - 32'h1);
        $display("test bank %0d write done", b);
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        for (int b = 0; b < 8; b++) begin
            bus(1'b0, {3'h0, b[2:0], 2'h0}, 32'h0, rd);
            chk(rd, 32'h1);
            bus(1'b0, {3'h1, b[2:0], 2'h0}, 32'h0, rd);
            chk(rd, {24'h0, mwr[2*b+:2], 6'h0});
            bus(1'b0, {3'h2, b[2:0], 2'h0}, 32'h0, rd);
            chk(rd, 32'h1f);
        end
        $display("test reset values done");
        bus(1'b1, 8'h0c, 32'hfffffff9, rd);
        bus(1'b0, 8'h0c, 32'h0, rd);
        chk(rd, 32'h9);
        bus(1'b1, 8'h2c, 32'hffffff7f, rd);
        bus(1'b0, 8'h2c, 32'h0, rd);
        chk(rd, 32'h40);
        bus(1'b1, 8'h60, 32'hffffffff, rd);
        bus(1'b0, 8'h60, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test reserved bits done");
        // delay kept at or below wait count in every case
        run(3'h0, 2'b10, 5'h2, 4'h1, 1'b1, 2'h2, 32'h1, 32'h1);
        run(3'h0, 2'b10, 5'h2, 4'h1, 1'b0, 2'h2, 32'h1, 32'h2);
        run(3'h5, 2'b10, 5'h3, 4'h0, 1'b1, 2'h2, 32'h1, 32'h3);
        run(3'h2, 2'b01, 5'h2, 4'h1, 1'b1, 2'h2, 32'h2, 32'h1);
        run(3'h1, 2'b00, 5'h1, 4'h0, 1'b1, 2'h2, 32'h4, 32'h1);
        run(3'h7, 2'b00, 5'h2, 4'h2, 1'b1, 2'h1, 32'h2, 32'h0);
        run(3'h6, 2'b10, 5'h4, 4'h3, 1'b1, 2'h2, 32'h1, 32'h1);
        run(3'h3, 2'b11, 5'h1, 4'h0, 1'b1, 2'h2, 32'h4, 32'h1);
        run(3'h4, 2'b10, 5'h0, 4'h0, 1'b1, 2'h2, 32'h1, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
